// *** hw/mssm_ctrl.sv ***
// Top: standby and sleep mode controller of the fan motor driver
`timescale 1ns/1ps
`default_nettype none
module mssm_ctrl
  import mssm_pkg::*;
#(
  parameter int unsigned QUAL_CYC = SLEEP_QUAL_CYC,
  parameter int unsigned WIN_CYC = DUTY_WIN_CYC,
  parameter int unsigned LOW_CYC = STBY_HIGH_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command pin: level and whether anyone drives it
  input wire logic pwm_in,
  input wire logic pwm_driven,
  // One-time configuration bit
  input wire logic otp_sleep_allow,
  // Motor measurement handshake
  input wire logic meas_done,
  output logic meas_clear,
  output logic meas_start,
  // Status
  output logic phase_hiz,
  output logic sleep_mode,
  output logic init_busy,
  output logic resync_ok
);
  mssm_state_t state, next_state;
  localparam int QW = $clog2(QUAL_CYC + 1);
  logic [QW-1:0] qual_cnt, next_qual_cnt;
  logic sleep_allow, next_sleep_allow;
  logic allow_read, next_allow_read;
  logic pwm_cmd;
  logic duty_low;
  logic win_done;
  logic qual_hit;
  logic sleep_req;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // A floating pin reads high, as the pull-up would make it
  assign pwm_cmd = pwm_in | ~pwm_driven;

  mssm_duty_meter #(
    .WIN_CYC(WIN_CYC),
    .LOW_CYC(LOW_CYC)
  ) u_meter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pwm_cmd(pwm_cmd),
    .duty_low(duty_low),
    .win_done(win_done)
  );

  // ----------------------------------------------------------------
  // Sleep qualification timer and configuration capture
  // ----------------------------------------------------------------
  assign qual_hit = (qual_cnt == QW'(QUAL_CYC));

  // Sleep needs both a full low interval and the one-time permission
  assign sleep_req = qual_hit && sleep_allow;

  // Latch the one-time bit once after reset release, never under reset
  always_comb begin
    next_allow_read = 1'b1;
    next_sleep_allow = allow_read ? sleep_allow
                                  : (otp_sleep_allow == SLEEP_ALLOW_ON);
    if (pwm_cmd) begin
      next_qual_cnt = '0;
    end else if (qual_hit) begin
      next_qual_cnt = qual_cnt;
    end else begin
      next_qual_cnt = qual_cnt + QW'(1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      qual_cnt <= '0;
      sleep_allow <= 1'b0;
      allow_read <= 1'b0;
    end else begin
      qual_cnt <= next_qual_cnt;
      sleep_allow <= next_sleep_allow;
      allow_read <= next_allow_read;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  // Sleep takes priority over standby since it is the deeper state
  always_comb begin
    next_state = state;
    unique case (state)
      MSSM_ST_RESET: begin
        if (allow_read) begin
          next_state = MSSM_ST_INIT;
        end
      end
      MSSM_ST_INIT: begin
        if (sleep_req) begin
          next_state = MSSM_ST_SLEEP;
        end else if (meas_done) begin
          next_state = MSSM_ST_RUN;
        end
      end
      MSSM_ST_RUN: begin
        if (sleep_req) begin
          next_state = MSSM_ST_SLEEP;
        end else if (win_done && duty_low) begin
          next_state = MSSM_ST_STANDBY;
        end
      end
      MSSM_ST_STANDBY: begin
        if (sleep_req) begin
          next_state = MSSM_ST_SLEEP;
        end else if (win_done && !duty_low) begin
          // Without sleep the values survive, so resume without re-init
          next_state = MSSM_ST_RUN;
        end
      end
      MSSM_ST_SLEEP: begin
        if (pwm_cmd) begin
          next_state = MSSM_ST_RESET;
        end
      end
      default: next_state = MSSM_ST_RESET;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= MSSM_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Decode of the states in which the bridge may drive the phases
  function automatic logic drives_phases(input mssm_state_t s);
    return (s == MSSM_ST_RUN) || (s == MSSM_ST_INIT);
  endfunction : drives_phases

  // Phases drive in the running and init states; hi-Z in reset, standby and sleep
  assign phase_hiz = !drives_phases(state);
  assign sleep_mode = (state == MSSM_ST_SLEEP);
  assign init_busy = (state == MSSM_ST_INIT);
  assign meas_clear = (state == MSSM_ST_RESET);
  assign meas_start = (state == MSSM_ST_RESET) && allow_read;
  assign resync_ok = ~sleep_allow & allow_read;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks lean on the default disable, so none fires while reset holds
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  standby_hiz_a: assert property (state == MSSM_ST_STANDBY
                                  |-> phase_hiz)
    else $error("phases driven in standby");
  sleep_entry_a: assert property ($rose(sleep_mode) |-> $past(qual_hit))
    else $error("sleep entered without full low interval");
  sleep_hold_a: assert property (sleep_mode && !pwm_cmd |=> sleep_mode)
    else $error("sleep left while input low");
  float_wake_a: assert property (sleep_mode && !pwm_driven
                                 |=> !sleep_mode)
    else $error("floating input did not wake");
  wake_init_a: assert property (sleep_mode && pwm_cmd
                                |=> meas_clear ##1 init_busy)
    else $error("wake did not rerun initialization");
  init_clear_a: assert property ($rose(init_busy) |-> $past(meas_clear))
    else $error("init without clearing measurements");
  no_sleep_a: assert property (resync_ok |-> !sleep_mode)
    else $error("sleep while disabled");
  allow_stable_a: assert property (allow_read |=> $stable(sleep_allow))
    else $error("sleep-allow changed after start-up");
  qual_restart_a: assert property (pwm_cmd |=> qual_cnt == '0)
    else $error("timer not restarted by high input");

  // Outputs and transitions of the state machine, the sleep timer count and the capture of the one-time bit
  run_drive_a: assert property (state == MSSM_ST_RUN |-> !phase_hiz)
    else $error("phases not driven while running");
  start_pulse_a: assert property (meas_start
                                  |=> init_busy && !meas_start)
    else $error("measurement start not followed by init");
  standby_entry_a: assert property (state == MSSM_ST_RUN && win_done
                                    && duty_low && !sleep_req
                                    |=> state == MSSM_ST_STANDBY)
    else $error("low duty window did not enter standby");
  run_entry_a: assert property (init_busy && meas_done && !sleep_req
                                |=> state == MSSM_ST_RUN)
    else $error("finished measurement did not start running");
  qual_count_a: assert property (!pwm_cmd && !qual_hit
                                 |=> qual_cnt == $past(qual_cnt) + QW'(1))
    else $error("timer did not count a low sample");
  allow_capture_a: assert property ($rose(allow_read) |-> sleep_allow ==
      ($past(otp_sleep_allow) == SLEEP_ALLOW_ON))
    else $error("sleep-allow not taken from the one-time bit");

  // Main scenarios
  wake_c: cover property (sleep_mode ##1 !sleep_mode);
  sleep_c: cover property ($rose(sleep_mode));
  float_c: cover property (sleep_mode && !pwm_driven);
  standby_c: cover property (state == MSSM_ST_RUN ##1
                             state == MSSM_ST_STANDBY);
  resume_c: cover property (state == MSSM_ST_STANDBY ##1
                            state == MSSM_ST_RUN);
endmodule : mssm_ctrl
`default_nettype wire

// *** hw/mssm_duty_meter.sv ***
// Duty meter: counts high samples of the PWM command over a fixed window
`timescale 1ns/1ps
`default_nettype none
module mssm_duty_meter
  import mssm_pkg::*;
#(
  parameter int unsigned WIN_CYC = DUTY_WIN_CYC,
  parameter int unsigned LOW_CYC = STBY_HIGH_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command input, pull-up already resolved
  input wire logic pwm_cmd,
  // Result, updated once per window
  output logic duty_low,
  output logic win_done
);
  localparam int W = $clog2(WIN_CYC + 1);
  logic [W-1:0] win_cnt, next_win_cnt;
  logic [W-1:0] high_cnt, next_high_cnt;
  logic next_duty_low;
  logic next_win_done;

  // ----------------------------------------------------------------
  // Window counting
  // ----------------------------------------------------------------
  // Whole-window average rejects single glitches at the cost of latency
  always_comb begin
    next_win_done = 1'b0;
    next_duty_low = duty_low;
    next_win_cnt = win_cnt + W'(1);
    next_high_cnt = high_cnt + W'(pwm_cmd);
    if (win_cnt == W'(WIN_CYC - 1)) begin
      next_win_done = 1'b1;
      next_duty_low = (next_high_cnt < W'(LOW_CYC));
      next_win_cnt = '0;
      next_high_cnt = '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      win_cnt <= '0;
      high_cnt <= '0;
      duty_low <= 1'b1;
      win_done <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      high_cnt <= next_high_cnt;
      duty_low <= next_duty_low;
      win_done <= next_win_done;
    end
  end
endmodule : mssm_duty_meter
`default_nettype wire

// *** hw/mssm_pkg.sv ***
// Package: constants for the motor standby and sleep mode controller
package mssm_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SLEEP_QUAL_US = 1000;
  localparam int unsigned SLEEP_QUAL_CYC = (SLEEP_QUAL_US * (CLK_HZ / 1000000));
  // Duty measurement: one window of PWM samples, standby below 1.5 percent
  localparam int unsigned DUTY_WIN_CYC = 4000;
  localparam int unsigned STBY_PERMILLE = 15;
  localparam int unsigned STBY_HIGH_CYC = (DUTY_WIN_CYC * STBY_PERMILLE) / 1000;
  // Sleep-allow value that enables sleep
  localparam logic SLEEP_ALLOW_ON = 1'b1;
  // Mode states
  typedef enum logic [2:0] {
    MSSM_ST_RESET = 3'b000,
    MSSM_ST_INIT = 3'b001,
    MSSM_ST_RUN = 3'b010,
    MSSM_ST_STANDBY = 3'b011,
    MSSM_ST_SLEEP = 3'b100
  } mssm_state_t;
endpackage : mssm_pkg

// *** verification/mssm_host_model.sv ***
// Host model: drives the speed command pin as PWM, low, float or high
`timescale 1ns/1ps
`default_nettype none
module mssm_host_model #(
  parameter int unsigned PER = 200
) (
  // Clock
  input wire logic mclk,
  // Command: 0 PWM, 1 held low, 2 released, 3 held high
  input wire logic [1:0] mode,
  input wire logic [7:0] high_cyc,
  // Pin as the device sees it
  output logic pwm_in,
  output logic pwm_driven
);
  int cnt;
  // ---------------------------------------------------------------
  // Period counter, moved just after each edge
  // ---------------------------------------------------------------
  initial begin
    cnt = 0;
    forever begin
      @(posedge mclk);
      #1;
      cnt = (cnt + 1) % PER;
    end
  end
  // Released pin reads low here, so only the device's pull-up can wake it
  always_comb begin
    pwm_driven = (mode != 2'd2);
    case (mode)
      2'd0: pwm_in = (cnt < int'(high_cyc));
      2'd2: pwm_in = 1'b0;
      2'd3: pwm_in = 1'b1;
      default: pwm_in = 1'b0;
    endcase
  end
endmodule : mssm_host_model
`default_nettype wire

// *** verification/testbench.sv ***
// Testbench: standby and sleep mode controller against a host model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mssm_pkg::*;
  localparam int QC = 300;
  localparam int WC = 200;
  logic mclk, sys_rst, otp_sleep_allow, meas_done, pwm_in, pwm_driven;
  logic meas_clear, meas_start, phase_hiz, sleep_mode, init_busy, resync_ok;
  logic [1:0] mode;
  logic [7:0] high_cyc;
  wire logic [5:0] outs;
  int err_total, n_checks, seed, k;
  mssm_state_t want;
  assign outs = {phase_hiz, sleep_mode, init_busy, resync_ok, meas_clear,
                 meas_start};
  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  mssm_ctrl #(.QUAL_CYC(QC), .WIN_CYC(WC), .LOW_CYC(3)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .pwm_in(pwm_in), .pwm_driven(pwm_driven),
    .otp_sleep_allow(otp_sleep_allow), .meas_done(meas_done),
    .meas_clear(meas_clear), .meas_start(meas_start), .phase_hiz(phase_hiz),
    .sleep_mode(sleep_mode), .init_busy(init_busy), .resync_ok(resync_ok));
  mssm_host_model #(.PER(WC)) host (.mclk(mclk), .mode(mode),
    .high_cyc(high_cyc), .pwm_in(pwm_in), .pwm_driven(pwm_driven));
  // Expected outputs for one state; window period equals the PWM period
  function automatic logic [5:0] exp_st(input mssm_state_t s,
                                        input logic allow, input logic go);
    exp_st = {!(s == MSSM_ST_RUN || s == MSSM_ST_INIT), s == MSSM_ST_SLEEP,
              s == MSSM_ST_INIT, !allow, s == MSSM_ST_RESET, go};
  endfunction : exp_st
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : ticks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // Motor left to stop before the measurement is reported done
  task automatic finish_init(input logic allow);
    chk(outs, exp_st(MSSM_ST_INIT, allow, 1'b0));
    ticks(30);
    meas_done = 1'b1;
    ticks(1);
    meas_done = 1'b0;
    chk(outs, exp_st(MSSM_ST_RUN, allow, 1'b0));
  endtask : finish_init
  task automatic boot(input logic allow);
    sys_rst = 1'b1;
    otp_sleep_allow = allow;
    ticks(20);
    chk(outs, 6'h22);
    sys_rst = 1'b0;
    ticks(1);
    chk(outs, exp_st(MSSM_ST_RESET, allow, 1'b1));
    ticks(1);
    finish_init(allow);
    $display("boot done");
  endtask : boot
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h7f2c3c11;
    err_total = 0;
    n_checks = 0;
    meas_done = 1'b0;
    mode = 2'd0;
    high_cyc = 8'h64;
    boot(SLEEP_ALLOW_ON);
    // Random duties, then both sides of the standby threshold
    for (k = 0; k < 6; k++) begin
      high_cyc = 8'(10 + ($unsigned($random(seed)) % 150));
      if (k == 4) high_cyc = 8'h02;
      if (k == 5) high_cyc = 8'h03;
      ticks(2 * WC + 5);
      want = (k == 4) ? MSSM_ST_STANDBY : MSSM_ST_RUN;
      chk(outs, exp_st(want, 1'b1, 1'b0));
    end
    $display("duty test done");
    // A single high sample restarts the sleep timer; start from a clear
    // timer, since the low tail of the last PWM period already counts
    mode = 2'd3;
    ticks(1);
    mode = 2'd1;
    ticks(QC - 10);
    mode = 2'd3;
    ticks(1);
    mode = 2'd1;
    ticks(QC - 10);
    chk(outs, exp_st(MSSM_ST_STANDBY, 1'b1, 1'b0));
    // Sleep, stray measurement ignored, then wake by float and by high
    for (k = 2; k < 4; k++) begin
      mode = 2'd1;
      ticks(QC + 20);
      chk(outs, exp_st(MSSM_ST_SLEEP, 1'b1, 1'b0));
      meas_done = 1'b1;
      ticks(40);
      meas_done = 1'b0;
      chk(outs, exp_st(MSSM_ST_SLEEP, 1'b1, 1'b0));
      mode = 2'(k);
      ticks(1);
      chk(outs, exp_st(MSSM_ST_RESET, 1'b1, 1'b1));
      ticks(1);
      finish_init(1'b1);
    end
    $display("sleep test done");
    // With sleep disallowed a long low input only reaches standby
    mode = 2'd0;
    boot(1'b0);
    mode = 2'd1;
    ticks(QC + 100);
    chk(outs, exp_st(MSSM_ST_STANDBY, 1'b0, 1'b0));
    $display("no-sleep test done");
    wrap_up();
  end
  // Watchdog: the scenarios need far fewer cycles than this
  initial begin
    #(40 * 20000);
    err_total++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
